/* hdl/aic_pkg.sv */
// Constants for the activity indicator control block.
// Assumes a single 125 MHz clock and a 12-bit AXI4-Lite byte address.
package aic_pkg;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [11:0] REG_CTRL_ADDR   = 12'h080;
   localparam logic [11:0] REG_THRESH_ADDR = 12'h084;
   localparam logic [11:0] REG_BLINK_ADDR  = 12'h088;
   localparam logic [11:0] REG_STATUS_ADDR = 12'h08C;

   // ==========================================================
   // Control and status register fields
   localparam int CTRL_TEST_BIT = 31;
   localparam int CTRL_TYPE_BIT = 3;
   localparam int CTRL_POL_BIT  = 2;
   localparam int CTRL_SW_BIT   = 1;
   localparam int CTRL_EN_BIT   = 0;
   localparam int STAT_LAMP_BIT = 0;
   localparam int STAT_LOAD_BIT = 1;

   // ==========================================================
   // Reset values (no EEPROM image)
   localparam logic        RST_TEST         = 1'b0;
   localparam logic        RST_TYPE         = 1'b0;
   localparam logic        RST_POL          = 1'b0;
   localparam logic        RST_SW           = 1'b0;
   localparam logic        RST_EN           = 1'b1;
   localparam logic [15:0] THRESH_OFF       = 16'hFFFF;
   localparam logic [15:0] RST_FAST_BLINK   = 16'h0032;
   localparam logic [15:0] RST_SLOW_BLINK   = 16'h00FA;

   // ==========================================================
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ==========================================================
   // Timebase
   localparam longint CLOCK_HZ        = 125_000_000;
   localparam int     TICK_MS_TIME    = 1;
   localparam int     TICK_US_TIME    = 1;
   localparam int     TICK_MS_CYCLES  = int'(CLOCK_HZ / 1000 * TICK_MS_TIME);
   localparam int     TICK_US_CYCLES  = int'(CLOCK_HZ / 1_000_000 * TICK_US_TIME);
   localparam int     TICK_CNT_W      = 17;

   typedef enum logic [1:0] {
      BL_OFF    = 2'b00,
      BL_STEADY = 2'b01,
      BL_FAST   = 2'b10,
      BL_SLOW   = 2'b11
   } blink_mode_e;
endpackage

/* hdl/aic_cfg_if.sv */
// Configuration carried from the register bank to the blink engine.
// Assumes both ends run on the same clock.
interface aic_cfg_if;
   logic        enable;
   logic        swCtl;
   logic        tick;
   logic [15:0] trafficRate;
   logic [15:0] fastThr;
   logic [15:0] slowThr;
   logic [15:0] fastTime;
   logic [15:0] slowTime;
   logic        lampOn;

   modport regs (output enable, swCtl, tick, trafficRate, fastThr, slowThr,
                 output fastTime, slowTime, input lampOn);
   modport engine (input enable, swCtl, tick, trafficRate, fastThr, slowThr,
                   input fastTime, slowTime, output lampOn);
endinterface

/* hdl/aic_tick_gen.sv */
// Blink timebase divider: one pulse per ms, or per us in test mode.
// Assumes testMode comes from logic on the same clock.
module aic_tick_gen #(
   parameter int unsigned MS_CYCLES = aic_pkg::TICK_MS_CYCLES
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic nrst,
   // Control
   input  wire logic testMode,
   // Timebase
   output logic      tick
);
   localparam int CW = aic_pkg::TICK_CNT_W;
   localparam logic [CW-1:0] MS_LAST = CW'(MS_CYCLES - 1);
   localparam logic [CW-1:0] US_LAST = CW'(aic_pkg::TICK_US_CYCLES - 1);

   logic [CW-1:0] count;
   logic          modeQ;
   logic [CW-1:0] last;

   assign last = testMode ? US_LAST : MS_LAST;

   // Restart on a mode change so the first tick is a full period
   always_ff @(posedge clock) begin
      if (!nrst) begin
         count <= '0;
         modeQ <= 1'b0;
         tick  <= 1'b0;
      end else begin
         modeQ <= testMode;
         if (modeQ != testMode || count >= last) begin
            count <= '0;
         end else begin
            count <= count + CW'(1);
         end
         tick <= (modeQ == testMode) && (count >= last);
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);

   sequence s_us_tick;
      tick && testMode;
   endsequence

   sequence s_quiet_us;
      !tick [*8];
   endsequence

   // A mode change restarts the divider, so no tick follows soon either way
   a_us_no_early: assert property (s_us_tick |=> s_quiet_us)
      else $error("us tick repeated too soon");
   a_tick_period: assert property (tick |-> $past(count) == $past(last))
      else $error("tick not at end of divider period");
endmodule

/* hdl/aic_blink_engine.sv */
// Chooses steady, fast or slow blinking and toggles the lamp state.
// Assumes tick pulses come from the timebase divider on the same clock.
module aic_blink_engine (
   // Clock and reset
   input  wire logic clock,
   input  wire logic nrst,
   // Configuration and lamp state
   aic_cfg_if.engine cfg
);
   aic_pkg::blink_mode_e mode;
   logic [15:0]          period;
   logic [15:0]          count;
   logic                 lamp;
   logic                 fastHit;
   logic                 slowHit;

   assign fastHit = cfg.fastThr != aic_pkg::THRESH_OFF && cfg.trafficRate > cfg.fastThr;
   assign slowHit = cfg.slowThr != aic_pkg::THRESH_OFF && cfg.trafficRate > cfg.slowThr;
   assign cfg.lampOn = lamp;

   always_comb begin
      if (!cfg.enable) begin
         mode = aic_pkg::BL_OFF;
      end else if (cfg.swCtl) begin
         mode = aic_pkg::BL_SLOW;
      end else if (fastHit) begin
         mode = aic_pkg::BL_FAST;
      end else if (slowHit) begin
         mode = aic_pkg::BL_SLOW;
      end else if (cfg.fastThr == aic_pkg::THRESH_OFF && cfg.slowThr == aic_pkg::THRESH_OFF) begin
         mode = aic_pkg::BL_STEADY;
      end else begin
         mode = aic_pkg::BL_OFF;
      end
   end

   assign period = (mode == aic_pkg::BL_FAST) ? cfg.fastTime : cfg.slowTime;

   // Half period counted in ticks; a period of zero toggles on every tick
   always_ff @(posedge clock) begin
      if (!nrst) begin
         lamp  <= 1'b0;
         count <= '0;
      end else begin
         unique case (mode)
            aic_pkg::BL_OFF: begin
               lamp  <= 1'b0;
               count <= '0;
            end
            aic_pkg::BL_STEADY: begin
               lamp  <= 1'b1;
               count <= '0;
            end
            aic_pkg::BL_FAST, aic_pkg::BL_SLOW: begin
               if (cfg.tick) begin
                  if (count + 16'h0001 >= period) begin
                     count <= '0;
                     lamp  <= !lamp;
                  end else begin
                     count <= count + 16'h0001;
                  end
               end
            end
         endcase
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);

   a_sw_slow_rate: assert property (cfg.enable && cfg.swCtl |-> mode == aic_pkg::BL_SLOW && period == cfg.slowTime)
      else $error("software control not at slow blink time");
   a_fast_first: assert property (cfg.enable && !cfg.swCtl && fastHit |-> period == cfg.fastTime)
      else $error("fast threshold not given precedence");
   a_steady_on: assert property (cfg.enable && !cfg.swCtl && cfg.fastThr == 16'hFFFF
                                  && cfg.slowThr == 16'hFFFF |=> lamp)
      else $error("lamp not steady on with checks disabled");
   a_off_disabled: assert property (!cfg.enable |=> !lamp)
      else $error("lamp on while disabled");
endmodule

/* hdl/aic_indicator_top.sv */
// Activity indicator register bank, AXI4-Lite slave and pin driver.
// Assumes bus, EEPROM load and reset pulses come from same-clock logic.
//
// Operation
// - Test bit 31 gives microsecond blink ticks
// - Bit 3 set push-pull, clear open-drain
// - Bit 2 set: high pin means active
// - Software control blinks at slow blink time
// - Indicator works only while enable set
// - Reset protection keeps type, polarity, enable
// - Driver type from EEPROM, else zero
// - Polarity from EEPROM, else zero
// - Enable from EEPROM, else one
// - Bus or lite reset restores image values
// - Fast threshold checked first, then slow
// - All-ones threshold disables; both gives steady
module aic_indicator_top #(
   parameter int unsigned MS_TICK_CYCLES = aic_pkg::TICK_MS_CYCLES
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        nrst,
   // AXI4-Lite write address
   input  wire logic [11:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   // AXI4-Lite write data
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   // AXI4-Lite write response
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read address
   input  wire logic [11:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   // AXI4-Lite read data
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Device resets and EEPROM image
   input  wire logic        busReset,
   input  wire logic        liteReset,
   input  wire logic        resetProtect,
   input  wire logic        eepromLoad,
   input  wire logic        eepromDriverTypeFlag,
   input  wire logic        eepromPolarityFlag,
   input  wire logic        eepromEnableFlag,
   // Traffic monitor
   input  wire logic [15:0] trafficRate,
   // Indicator pin
   output logic             lampOut,
   output logic             lampOe_n
);
   // ==========================================================
   // Address decode
   // Returns {hit, index}; shared by the read and write paths
   function automatic logic [2:0] decodeReg(input logic [11:0] a);
      logic [2:0] r;
      r = 3'h0;
      if (a[11:2] == aic_pkg::REG_CTRL_ADDR[11:2]) begin
         r = 3'h4;
      end else if (a[11:2] == aic_pkg::REG_THRESH_ADDR[11:2]) begin
         r = 3'h5;
      end else if (a[11:2] == aic_pkg::REG_BLINK_ADDR[11:2]) begin
         r = 3'h6;
      end else if (a[11:2] == aic_pkg::REG_STATUS_ADDR[11:2]) begin
         r = 3'h7;
      end
      return r;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ==========================================================
   // Storage
   logic        ctrlTest;
   logic        ctrlType;
   logic        ctrlPol;
   logic        ctrlSw;
   logic        ctrlEn;
   logic        imgType;
   logic        imgPol;
   logic        imgEn;
   logic        eepromLoaded;
   logic [31:0] thresh;
   logic [31:0] blinkTime;
   logic        awHeld;
   logic        wHeld;
   logic [11:0] awAddrQ;
   logic [31:0] wDataQ;
   logic [3:0]  wStrbQ;
   logic        doWrite;
   logic [2:0]  wSel;
   logic [2:0]  rSel;
   logic        anyReset;
   logic        tick;
   logic [31:0] ctrlWord;
   logic [31:0] next_ctrl;

   aic_cfg_if cfg ();

   assign anyReset = busReset || liteReset;
   assign doWrite  = awHeld && wHeld && !bvalid;
   assign wSel     = decodeReg(awAddrQ);
   assign rSel     = decodeReg(araddr);
   assign awready  = !awHeld;
   assign wready   = !wHeld;
   assign arready  = !rvalid;

   assign ctrlWord = {ctrlTest, 27'h0000000, ctrlType, ctrlPol, ctrlSw, ctrlEn};
   assign next_ctrl = merge(ctrlWord, wDataQ, wStrbQ);

   // ==========================================================
   // AXI4-Lite write channels; address and data in either order
   always_ff @(posedge clock) begin
      if (!nrst) begin
         awHeld  <= 1'b0;
         awAddrQ <= 12'h000;
      end else if (awvalid && awready) begin
         awHeld  <= 1'b1;
         awAddrQ <= awaddr;
      end else if (doWrite) begin
         awHeld  <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         wHeld  <= 1'b0;
         wDataQ <= 32'h00000000;
         wStrbQ <= 4'h0;
      end else if (wvalid && wready) begin
         wHeld  <= 1'b1;
         wDataQ <= wdata;
         wStrbQ <= wstrb;
      end else if (doWrite) begin
         wHeld  <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         bvalid <= 1'b0;
         bresp  <= aic_pkg::RESP_OKAY;
      end else if (doWrite) begin
         bvalid <= 1'b1;
         bresp  <= wSel[2] ? aic_pkg::RESP_OKAY : aic_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Control register; EEPROM load beats reset restore beats software
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ctrlTest <= aic_pkg::RST_TEST;
         ctrlType <= aic_pkg::RST_TYPE;
         ctrlPol  <= aic_pkg::RST_POL;
         ctrlSw   <= aic_pkg::RST_SW;
         ctrlEn   <= aic_pkg::RST_EN;
      end else if (eepromLoad) begin
         ctrlType <= eepromDriverTypeFlag;
         ctrlPol  <= eepromPolarityFlag;
         ctrlEn   <= eepromEnableFlag;
      end else if (anyReset) begin
         ctrlTest <= aic_pkg::RST_TEST;
         ctrlSw   <= aic_pkg::RST_SW;
         if (!resetProtect) begin
            ctrlType <= imgType;
            ctrlPol  <= imgPol;
            ctrlEn   <= imgEn;
         end
      end else if (doWrite && wSel == 3'h4) begin
         ctrlTest <= next_ctrl[aic_pkg::CTRL_TEST_BIT];
         ctrlType <= next_ctrl[aic_pkg::CTRL_TYPE_BIT];
         ctrlPol  <= next_ctrl[aic_pkg::CTRL_POL_BIT];
         ctrlSw   <= next_ctrl[aic_pkg::CTRL_SW_BIT];
         ctrlEn   <= next_ctrl[aic_pkg::CTRL_EN_BIT];
      end
   end

   // Last loaded image, used for restore after bus or lite reset
   always_ff @(posedge clock) begin
      if (!nrst) begin
         imgType      <= aic_pkg::RST_TYPE;
         imgPol       <= aic_pkg::RST_POL;
         imgEn        <= aic_pkg::RST_EN;
         eepromLoaded <= 1'b0;
      end else if (eepromLoad) begin
         imgType      <= eepromDriverTypeFlag;
         imgPol       <= eepromPolarityFlag;
         imgEn        <= eepromEnableFlag;
         eepromLoaded <= 1'b1;
      end
   end

   // Thresholds are not preserved across any reset
   always_ff @(posedge clock) begin
      if (!nrst || anyReset) begin
         thresh <= {aic_pkg::THRESH_OFF, aic_pkg::THRESH_OFF};
      end else if (doWrite && wSel == 3'h5) begin
         thresh <= merge(thresh, wDataQ, wStrbQ);
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         blinkTime <= {aic_pkg::RST_FAST_BLINK, aic_pkg::RST_SLOW_BLINK};
      end else if (doWrite && wSel == 3'h6) begin
         blinkTime <= merge(blinkTime, wDataQ, wStrbQ);
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= aic_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rresp  <= rSel[2] ? aic_pkg::RESP_OKAY : aic_pkg::RESP_SLVERR;
         unique case (rSel)
            3'h4:    rdata <= ctrlWord;
            3'h5:    rdata <= thresh;
            3'h6:    rdata <= blinkTime;
            3'h7:    rdata <= {trafficRate, 14'h0000, eepromLoaded, cfg.lampOn};
            default: rdata <= 32'h00000000;
         endcase
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Timebase and blink engine
   assign cfg.enable      = ctrlEn;
   assign cfg.swCtl       = ctrlSw;
   assign cfg.tick        = tick;
   assign cfg.trafficRate = trafficRate;
   assign cfg.fastThr     = thresh[31:16];
   assign cfg.slowThr     = thresh[15:0];
   assign cfg.fastTime    = blinkTime[31:16];
   assign cfg.slowTime    = blinkTime[15:0];

   aic_tick_gen #(
      .MS_CYCLES (MS_TICK_CYCLES)
   ) u_tick (
      .clock    (clock),
      .nrst     (nrst),
      .testMode (ctrlTest),
      .tick     (tick)
   );

   aic_blink_engine u_blink (
      .clock (clock),
      .nrst  (nrst),
      .cfg   (cfg)
   );

   // ==========================================================
   // Pin driver; released while disabled so a GPIO can take the pin
   always_ff @(posedge clock) begin
      if (!nrst) begin
         lampOut  <= 1'b0;
         lampOe_n <= 1'b1;
      end else if (!ctrlEn) begin
         lampOut  <= 1'b0;
         lampOe_n <= 1'b1;
      end else if (ctrlType) begin
         lampOut  <= ctrlPol ~^ cfg.lampOn;
         lampOe_n <= 1'b0;
      end else begin
         lampOut  <= 1'b0;
         lampOe_n <= ctrlPol ~^ cfg.lampOn;
      end
   end

   // ==========================================================
   // Checks
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);

   sequence s_restore;
      anyReset && !resetProtect && !eepromLoad;
   endsequence

   a_pushpull_drive: assert property (ctrlEn && ctrlType |=> !lampOe_n)
      else $error("push-pull pin not driven");
   a_opendrain_low: assert property (ctrlEn && !ctrlType |=> !lampOut)
      else $error("open-drain pin drove high");
   a_polarity_level: assert property (ctrlEn && ctrlType |=>
                                      lampOut == ($past(ctrlPol) ~^ $past(cfg.lampOn)))
      else $error("pin level does not follow polarity");
   a_disabled_release: assert property (!ctrlEn |=> lampOe_n && !lampOut)
      else $error("pin driven while disabled");
   a_protect_hold: assert property (anyReset && resetProtect && !eepromLoad |=>
                                    $stable(ctrlType) && $stable(ctrlPol) && $stable(ctrlEn))
      else $error("protected bits disturbed by reset");
   a_restore_image: assert property (s_restore |=> ctrlType == imgType && ctrlPol == imgPol
                                     && ctrlEn == imgEn)
      else $error("reset did not restore image values");
   a_load_type: assert property (eepromLoad |=> ctrlType == $past(eepromDriverTypeFlag))
      else $error("driver type not loaded from image");
   a_load_pol: assert property (eepromLoad |=> ctrlPol == $past(eepromPolarityFlag))
      else $error("polarity not loaded from image");
   a_load_en: assert property (eepromLoad |=> ctrlEn == $past(eepromEnableFlag))
      else $error("enable not loaded from image");
   a_reset_defaults: assert property ($rose(nrst) |-> ctrlEn && !ctrlType && !ctrlPol)
      else $error("wrong defaults without image");
   a_test_tick: assert property (tick && ctrlTest && $past(ctrlTest) |=> !tick)
      else $error("back-to-back ticks in test mode");
endmodule

/* dv/aic_lamp_model.sv */
// Lamp on the indicator pin, with its pull-up resistor.
// Assumes the pin is released whenever the output enable is high.
module aic_lamp_model (
   // Pin driver
   input  wire logic lampOut,
   input  wire logic lampOe_n,
   // Wire level
   output logic      pinLevel
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // Pin level
   // A released pin floats up, so open-drain can only pull low
   assign pinLevel = lampOe_n ? 1'b1 : lampOut;
endmodule

/* dv/activity_indicator_control_test.sv */
// Self-checking bench for the activity indicator register bank.
// Assumes a pulled-up lamp pin and a shortened millisecond divider.
module activity_indicator_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} aic_row_s;
   typedef struct {logic [31:0] c; logic [31:0] t; logic [15:0] q; int p;} aic_blk_s;
   logic        clock = 1'b0, nrst = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000, rdata, rd;
   logic [3:0]  wstrb = 4'hF;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, lampOut, lampOe_n, pinLevel;
   logic [1:0]  bresp, rresp, rsp;
   logic        busReset = 1'b0, liteReset = 1'b0, resetProtect = 1'b0, eepromLoad = 1'b0;
   logic        eepromDriverTypeFlag = 1'b0, eepromPolarityFlag = 1'b0, eepromEnableFlag = 1'b0;
   logic [15:0] trafficRate = 16'h0000;
   int          errTotal = 0, nTests = 0, cycles = 0, n;
   aic_row_s rows[4] = '{
      '{aic_pkg::REG_CTRL_ADDR, 32'hFFFF_FFFF, 32'h8000_000F, aic_pkg::RESP_OKAY},
      '{aic_pkg::REG_CTRL_ADDR, 32'h0000_0000, 32'h0000_0000, aic_pkg::RESP_OKAY},
      '{aic_pkg::REG_THRESH_ADDR, 32'h1234_5678, 32'h1234_5678, aic_pkg::RESP_OKAY},
      '{12'h0F0, 32'hFFFF_FFFF, 32'h0000_0000, aic_pkg::RESP_SLVERR}};
   aic_blk_s blk[6] = '{
      '{32'h0000_000B, 32'hFFFF_FFFF, 16'h0000, 40},
      '{32'h8000_000B, 32'hFFFF_FFFF, 16'h0000, 250},
      '{32'h0000_000D, 32'h0010_0008, 16'h0020, 20},
      '{32'h0000_000D, 32'h0010_0008, 16'h000C, 40},
      '{32'h0000_000B, 32'h0010_0008, 16'h0020, 40},
      '{32'h0000_0005, 32'h0010_0008, 16'h0020, 20}};

   aic_indicator_top #(.MS_TICK_CYCLES(20)) aic_indicator_top_inst (
      .clock, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .busReset, .liteReset, .resetProtect, .eepromLoad, .eepromDriverTypeFlag,
      .eepromPolarityFlag, .eepromEnableFlag, .trafficRate, .lampOut, .lampOe_n);
   aic_lamp_model aic_lamp_model_inst (.lampOut, .lampOe_n, .pinLevel);

   always #4 clock = ~clock;

   // ==========
   // Checks
   task automatic chkData(input logic [31:0] g, input logic [31:0] e);
      nTests++;
      if (g !== e) begin
         errTotal++;
         $display("[FAIL] %0t data %h expected %h", $time, g, e);
      end
   endtask
   task automatic chkBits(input logic [1:0] g, input logic [1:0] e);
      nTests++;
      if (g !== e) begin
         errTotal++;
         $display("[FAIL] %0t bits %b expected %b", $time, g, e);
      end
   endtask
   task automatic chkCount(input int g, input int e);
      nTests++;
      if (g != e) begin
         errTotal++;
         $display("[FAIL] %0t count %0d expected %0d", $time, g, e);
      end
   endtask

   // ==========
   // Bus master
   // Each task ends one edge late so the next call never reassigns a strobe
   task automatic axWrite(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic busy;
      busy = 1'b1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (busy) begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
            busy = 1'b0;
         end
      end
      @(posedge clock);
   endtask
   task automatic axRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic busy;
      busy = 1'b1;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (busy) begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            busy = 1'b0;
         end
      end
      @(posedge clock);
   endtask
   task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
      axRead(a, rd, rsp);
      chkData(rd, e);
   endtask
   // Skips one partial half period, then times a whole one
   task automatic measure(output int k);
      logic p;
      int w;
      w = 0;
      p = pinLevel;
      while (pinLevel === p && w < 2000) begin
         @(posedge clock);
         w++;
      end
      p = pinLevel;
      k = 0;
      while (pinLevel === p && k < 2000) begin
         @(posedge clock);
         k++;
      end
   endtask

   task automatic print_verdict;
      if (errTotal == 0 && nTests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         errTotal++;
         print_verdict();
      end
   end

   // ==========
   // Sequence
   initial begin
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      rdChk(aic_pkg::REG_CTRL_ADDR, 32'h0000_0001);
      rdChk(aic_pkg::REG_THRESH_ADDR, 32'hFFFF_FFFF);
      rdChk(aic_pkg::REG_BLINK_ADDR, {aic_pkg::RST_FAST_BLINK, aic_pkg::RST_SLOW_BLINK});
      chkBits({lampOe_n, pinLevel}, 2'b00);
      foreach (rows[i]) begin
         axWrite(rows[i].a, rows[i].d, rsp);
         chkBits(rsp, rows[i].r);
         axRead(rows[i].a, rd, rsp);
         chkBits(rsp, rows[i].r);
         chkData(rd, rows[i].e);
      end
      chkBits({lampOe_n, pinLevel}, 2'b11);
      axWrite(aic_pkg::REG_BLINK_ADDR, 32'h0001_0002, rsp);
      foreach (blk[i]) begin
         trafficRate <= blk[i].q;
         axWrite(aic_pkg::REG_THRESH_ADDR, blk[i].t, rsp);
         axWrite(aic_pkg::REG_CTRL_ADDR, blk[i].c, rsp);
         measure(n);
         chkCount(n, blk[i].p);
      end
      axWrite(aic_pkg::REG_THRESH_ADDR, 32'hFFFF_FFFF, rsp);
      axWrite(aic_pkg::REG_CTRL_ADDR, 32'h0000_000D, rsp);
      repeat (3) @(posedge clock);
      chkBits({lampOe_n, pinLevel}, 2'b01);
      eepromDriverTypeFlag <= 1'b1;
      eepromPolarityFlag <= 1'b1;
      eepromLoad <= 1'b1;
      @(posedge clock);
      eepromLoad <= 1'b0;
      rdChk(aic_pkg::REG_CTRL_ADDR, 32'h0000_000C);
      rdChk(aic_pkg::REG_STATUS_ADDR, 32'h0020_0002);
      axWrite(aic_pkg::REG_CTRL_ADDR, 32'h8000_0003, rsp);
      busReset <= 1'b1;
      @(posedge clock);
      busReset <= 1'b0;
      rdChk(aic_pkg::REG_CTRL_ADDR, 32'h0000_000C);
      axWrite(aic_pkg::REG_CTRL_ADDR, 32'h0000_0003, rsp);
      resetProtect <= 1'b1;
      liteReset <= 1'b1;
      @(posedge clock);
      liteReset <= 1'b0;
      rdChk(aic_pkg::REG_CTRL_ADDR, 32'h0000_0001);
      // Mid-run reset drops the loaded image and relights the lamp steadily
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      rdChk(aic_pkg::REG_STATUS_ADDR, 32'h0020_0001);
      print_verdict();
   end
endmodule
